// ===== bench/ref_source.sv
`timescale 1ns/1ps
module ref_source (
    input  wire clk_sys,           // Clock.
    input  wire run,               // High lets it toggle.
    output reg  reference_clock_in = 1'b0 // Reference to the buffer.
);
    reg [1:0] div_ff = 2'h0;
    // Divide by six keeps the reference under half the system rate; stopped, it stands still.
    always @(posedge clk_sys) begin
        if (run) begin
            div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
            if (div_ff == 2'h2) begin
                reference_clock_in <= ~reference_clock_in;
            end
        end
    end
endmodule

// ===== bench/seq_checker.sv
`timescale 1ns/1ps
module seq_checker #(parameter NUM_OUT = 12) (
    input wire               clk_sys,           // Clock.
    input wire               rst_n,             // Reset.
    input wire               supplyValid,       // Supply.
    input wire               pllLock,           // Lock.
    input wire               pllBypass,         // Bypass.
    input wire               reference_clock_in, // Reference.
    input wire [NUM_OUT-1:0] diffTrueOe_n,      // True enables.
    input wire [NUM_OUT-1:0] diffCompOe_n,      // Comp enables.
    input wire               power_down_assert, // Power-down.
    input wire [3:0]         seqState           // State.
);
    reg [7:0] refIdle_ff;
    reg       refLast_ff;
    // Idle count of the reference pin; it saturates so a dead source never wraps to zero.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            refIdle_ff <= 8'h00;
            refLast_ff <= 1'b0;
        end else begin
            refLast_ff <= reference_clock_in;
            refIdle_ff <= (reference_clock_in != refLast_ff) ? 8'h00 :
                          (refIdle_ff == 8'hFF) ? 8'hFF : refIdle_ff + 8'h01;
        end
    end
    // All checks share one clock and the raw reset.
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence sDelay;
        (seqState == 4'h2) [*8];
    endsequence
    chk_float_pd: assert property ($rose(power_down_assert) |-> ##[0:2] &diffTrueOe_n)
        else $error("driving in power-down");
    chk_drive_run: assert property (seqState == 4'h8 |-> ~|diffTrueOe_n && ~|diffCompOe_n)
        else $error("run without drive");
    chk_idle_float: assert property (seqState != 4'h8 |-> &diffTrueOe_n && &diffCompOe_n)
        else $error("drive outside run");
    chk_enter_delay: assert property ($rose(seqState == 4'h2) |-> $past(seqState) == 4'h1)
        else $error("delay not from off");
    chk_delay_len: assert property ($rose(seqState == 4'h2) |-> sDelay ##1 seqState != 4'h2)
        else $error("delay length");
    // The power-down output lags the filtered level by one edge, as the state code
    // does, so running and asserted power-down must never be seen together.
    chk_pd_wait: assert property (seqState == 4'h8 |-> !power_down_assert)
        else $error("running in power-down");
    chk_lock_need: assert property (((!pllBypass && !pllLock) [*6] ##0 seqState == 4'h4)
        |=> seqState != 4'h8) else $error("run without lock");
    chk_no_ref: assert property (refIdle_ff > 8'h50 |-> seqState != 4'h8)
        else $error("run without reference");
    chk_supply_off: assert property ((!supplyValid) [*8] |-> seqState == 4'h1)
        else $error("not off after supply loss");
endmodule
bind clock_buffer_powerup_sequencer seq_checker #(.NUM_OUT(NUM_OUT)) u_seq_checker (.*);

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg         clk_sys = 1'b0;
    reg         rst_n = 1'b0;
    reg         supplyValid = 1'b0;
    reg         pdIn = 1'b1;
    reg         pllLock = 1'b0;
    reg         mirrorStable = 1'b0;
    reg         pllBypass = 1'b0;
    reg         refRun = 1'b0;
    wire        refClk;
    wire [11:0] outT, outC, oeT_n, oeC_n;
    wire        pdSeen;
    wire [3:0]  st;
    integer     fails = 0;
    integer     compares = 0;
    integer     n;
    // Clock at 200 MHz.
    always #2.5 clk_sys = ~clk_sys;
    ref_source u_ref_source (.clk_sys(clk_sys), .run(refRun), .reference_clock_in(refClk));
    clock_buffer_powerup_sequencer #(.STARTUP_CYC(8)) u_clock_buffer_powerup_sequencer (
        .clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'b1), .supplyValid(supplyValid),
        .power_down_input(pdIn), .reference_clock_in(refClk), .pllLock(pllLock),
        .mirrorStable(mirrorStable), .pllBypass(pllBypass), .clkTrue(12'h5A3),
        .diff_clock_out_true(outT), .diff_clock_out_comp(outC), .diffTrueOe_n(oeT_n),
        .diffCompOe_n(oeC_n), .power_down_assert(pdSeen), .seqState(st));
    task check(input [11:0] seen, input [11:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
            end
        end
    endtask
    // Bounded wait for a state, sampling well after the edge.
    task await(input [3:0] s, input integer limit);
        begin
            n = 0;
            while (st !== s && n < limit) begin
                @(posedge clk_sys);
                #1;
                n = n + 1;
            end
        end
    endtask
    task t_powerup;
        begin
            supplyValid <= 1'b1;
            pdIn <= 1'b0;
            pllLock <= 1'b1;
            refRun <= 1'b1;
            await(4'h2, 20);
            check(st, 4'h2);
            await(4'h8, 100);
            check({11'h000, n >= 8}, 12'h001);
            check(st, 4'h8);
            repeat (3) @(posedge clk_sys);
            #1;
            check(outT, 12'h5A3);
            check(outC, 12'hA5C);
        end
    endtask
    task t_pd;
        begin
            @(posedge clk_sys);
            pdIn <= 1'b1;
            await(4'h4, 20);
            check(oeC_n, 12'hFFF);
            check({11'h000, pdSeen}, 12'h001);
            @(posedge clk_sys);
            pdIn <= 1'b0;
            await(4'h8, 20);
            check(st, 4'h8);
        end
    endtask
    task t_noref;
        begin
            @(posedge clk_sys);
            refRun <= 1'b0;
            await(4'h4, 120);
            check(oeT_n, 12'hFFF);
            @(posedge clk_sys);
            refRun <= 1'b1;
            await(4'h8, 40);
            check(st, 4'h8);
        end
    endtask
    task t_lock;
        begin
            @(posedge clk_sys);
            supplyValid <= 1'b0;
            await(4'h1, 20);
            check(st, 4'h1);
            @(posedge clk_sys);
            pllLock <= 1'b0;
            supplyValid <= 1'b1;
            await(4'h4, 60);
            repeat (20) @(posedge clk_sys);
            #1;
            check(st, 4'h4);
            @(posedge clk_sys);
            pllBypass <= 1'b1;
            mirrorStable <= 1'b1;
            await(4'h8, 20);
            check(st, 4'h8);
        end
    endtask
    task summarize;
        begin
            if (fails == 0 && compares > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    // Reset for eight cycles, then the scenarios in turn.
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_powerup;
        t_pd;
        t_noref;
        t_lock;
        summarize;
    end
    // The run needs well under a thousand cycles; this cuts a hang short.
    initial begin
        #20000;
        fails = fails + 1;
        summarize;
    end
endmodule

// ===== pkg/clock_buffer_defines.vh
`ifndef CLOCK_BUFFER_DEFINES_VH
`define CLOCK_BUFFER_DEFINES_VH

// System clock period in picoseconds (200 MHz).
`define CLK_PERIOD_PS       5000
// Start-up delay window, in microseconds (0.2 ms to 0.3 ms).
`define STARTUP_MIN_US      200
`define STARTUP_MAX_US      300
// Power-on to outputs-active limit, in microseconds (1 ms).
`define POWERUP_LIMIT_US    1000
// Least start-up delay in cycles, rounded up.
`define STARTUP_CYCLES      ((`STARTUP_MIN_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Power-up limit in cycles, rounded down.
`define POWERUP_CYCLES      ((`POWERUP_LIMIT_US * 1000000) / `CLK_PERIOD_PS)
// Reference clock activity watchdog: system cycles without a reference edge.
`define REF_TIMEOUT_CYCLES  64
// Width of the start-up counter.
`define STARTUP_CNT_W       18
// Width of the activity watchdog counter.
`define REF_CNT_W           8

`endif

// ===== verilog/clock_buffer_powerup_sequencer.v
// Behaviour
// - Power-down high floats every output pair.
// - Supply valid starts the 0.2-0.3 ms delay.
// - Wait for reference clock and power-down release.
// - Enable outputs after lock or mirror stable.
// - Power-on to outputs active under 1 ms.
// - No reference clock keeps outputs disabled.
// - Bypass mode needs no PLL lock.
`timescale 1ns/1ps
`include "clock_buffer_defines.vh"

module clock_buffer_powerup_sequencer #(
    parameter NUM_OUT      = 12,
    parameter STARTUP_CYC  = `STARTUP_CYCLES,
    parameter CNT_W        = `STARTUP_CNT_W
) (
    input  wire               clk_sys,              // System clock, 200 MHz.
    input  wire               rst_n,                // Asynchronous reset, active low.
    input  wire               clkEn,                // Freezes all state but the reset synchroniser while low.
    input  wire               supplyValid,          // Supply detector, asynchronous.
    input  wire               power_down_input,     // Power-down pin, high floats outputs.
    input  wire               reference_clock_in,   // Reference clock pin.
    input  wire               pllLock,              // PLL lock indication.
    input  wire               mirrorStable,         // Current mirror stable indication.
    input  wire               pllBypass,            // High selects PLL bypass mode.
    input  wire [NUM_OUT-1:0] clkTrue,              // Internal clock for the true halves.
    output reg  [NUM_OUT-1:0] diff_clock_out_true,  // True output halves.
    output reg  [NUM_OUT-1:0] diff_clock_out_comp,  // Complement output halves.
    output reg  [NUM_OUT-1:0] diffTrueOe_n,         // True halves enable, low drives.
    output reg  [NUM_OUT-1:0] diffCompOe_n,         // Complement halves enable, low drives.
    output reg                power_down_assert,    // Power-down seen after filtering.
    output reg  [3:0]         seqState              // Current sequencer state, one-hot.
);

    // One-hot states: power-off, start-up delay, wait for inputs, outputs running.
    // seqState shows the same codes so the far side can watch the bring-up.
    localparam [3:0] ST_OFF   = 4'h1;
    localparam [3:0] ST_DELAY = 4'h2;
    localparam [3:0] ST_WAIT  = 4'h4;
    localparam [3:0] ST_RUN   = 4'h8;

    // Reset is released through two flops so removal is synchronous.
    reg rstMeta_ff;
    reg rstSync_ff;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end
    wire rstSync_n = rstSync_ff;

    // Three-stage synchronisers for the pin inputs; a change counts when
    // stages two and three agree, which also filters a one-cycle glitch.
    reg [2:0] supSync_ff;
    reg [2:0] pdSync_ff;
    reg [2:0] refSync_ff;
    reg [2:0] lockSync_ff;
    reg [2:0] mirSync_ff;
    reg       supValid_ff;
    reg       pdLevel_ff;
    reg       lockLevel_ff;
    reg       mirLevel_ff;

    function agree;
        input [2:0] s;
        begin
            agree = (s[1] == s[2]);
        end
    endfunction

    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            supSync_ff   <= 3'h0;
            pdSync_ff    <= 3'h7;
            refSync_ff   <= 3'h0;
            lockSync_ff  <= 3'h0;
            mirSync_ff   <= 3'h0;
            supValid_ff  <= 1'b0;
            pdLevel_ff   <= 1'b1;
            lockLevel_ff <= 1'b0;
            mirLevel_ff  <= 1'b0;
        end else if (clkEn) begin
            supSync_ff  <= {supSync_ff[1:0], supplyValid};
            pdSync_ff   <= {pdSync_ff[1:0], power_down_input};
            refSync_ff  <= {refSync_ff[1:0], reference_clock_in};
            lockSync_ff <= {lockSync_ff[1:0], pllLock};
            mirSync_ff  <= {mirSync_ff[1:0], mirrorStable};
            if (agree(supSync_ff)) begin
                supValid_ff <= supSync_ff[2];
            end
            if (agree(pdSync_ff)) begin
                pdLevel_ff <= pdSync_ff[2];
            end
            if (agree(lockSync_ff)) begin
                lockLevel_ff <= lockSync_ff[2];
            end
            if (agree(mirSync_ff)) begin
                mirLevel_ff <= mirSync_ff[2];
            end
        end
    end

    // Reference activity watchdog works on the third synchroniser stage.
    // Limitation: it sees activity, not frequency, so a reference at the
    // wrong rate still counts as valid as long as it keeps toggling.
    wire refValid;
    ref_clock_detect u_refDetect (
        .clk_sys     (clk_sys),
        .rstSync_n   (rstSync_n),
        .clkEn       (clkEn),
        .refSample   (refSync_ff[2]),
        .refValid_ff (refValid)
    );

    // Bypass mode waits for the mirror only; PLL mode needs lock.
    // Bypass is a same-domain strap and is read without synchronisation,
    // so a change while waiting takes effect on the very next edge.
    wire readyPath = pllBypass ? mirLevel_ff : lockLevel_ff;

    reg [3:0]       state_ff;
    reg [3:0]       nxt_state;
    reg [CNT_W-1:0] dlyCnt_ff;
    reg [CNT_W-1:0] nxt_dlyCnt;

    // Sequencer next state. Losing supply always wins, from any state.
    always @* begin
        nxt_state  = state_ff;
        nxt_dlyCnt = dlyCnt_ff;
        if (!supValid_ff) begin
            nxt_state  = ST_OFF;
            nxt_dlyCnt = {CNT_W{1'b0}};
        end else begin
            case (state_ff)
                ST_OFF: begin
                    nxt_state  = ST_DELAY;
                    nxt_dlyCnt = {CNT_W{1'b0}};
                end
                ST_DELAY: begin
                    // Shortest legal delay keeps the whole bring-up under 1 ms.
                    if (dlyCnt_ff == STARTUP_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1}) begin
                        nxt_state = ST_WAIT;
                    end else begin
                        nxt_dlyCnt = dlyCnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                ST_WAIT: begin
                    // The inputs may settle in any order; all are re-checked each cycle.
                    if (refValid && !pdLevel_ff && readyPath) begin
                        nxt_state = ST_RUN;
                    end
                end
                ST_RUN: begin
                    // A dropped reference disables the outputs again.
                    if (!refValid || pdLevel_ff) begin
                        nxt_state = ST_WAIT;
                    end
                end
                default: begin
                    nxt_state = ST_OFF;
                end
            endcase
        end
    end

    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_ff  <= ST_OFF;
            dlyCnt_ff <= {CNT_W{1'b0}};
        end else if (clkEn) begin
            state_ff  <= nxt_state;
            dlyCnt_ff <= nxt_dlyCnt;
        end
    end

    // Output drivers register the next state so outputs come from flops.
    // Decoding the next state costs a longer path into the drivers, but keeps
    // seqState and the enables changing on the same edge.
    wire drive = (nxt_state == ST_RUN) && !pdLevel_ff;

    // Per-pair next values: both halves share one enable, so a pair always
    // floats and returns as a whole, and a floated pair rests low.
    wire [NUM_OUT-1:0] nxtTrue;
    wire [NUM_OUT-1:0] nxtComp;
    wire [NUM_OUT-1:0] nxtOe_n;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi = gi + 1) begin : g_pair
            assign nxtTrue[gi] = drive & clkTrue[gi];
            assign nxtComp[gi] = drive & ~clkTrue[gi];
            assign nxtOe_n[gi] = ~drive;
        end
    endgenerate

    // Pair drivers and their enables.
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            diff_clock_out_true <= {NUM_OUT{1'b0}};
            diff_clock_out_comp <= {NUM_OUT{1'b0}};
            diffTrueOe_n        <= {NUM_OUT{1'b1}};
            diffCompOe_n        <= {NUM_OUT{1'b1}};
        end else if (clkEn) begin
            diff_clock_out_true <= nxtTrue;
            diff_clock_out_comp <= nxtComp;
            diffTrueOe_n        <= nxtOe_n;
            diffCompOe_n        <= nxtOe_n;
        end
    end

    // Status outputs: the filtered power-down level and the state code.
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            power_down_assert <= 1'b1;
            seqState          <= ST_OFF;
        end else if (clkEn) begin
            power_down_assert <= pdLevel_ff;
            seqState          <= nxt_state;
        end
    end

endmodule

// ===== verilog/ref_clock_detect.v
`timescale 1ns/1ps
`include "clock_buffer_defines.vh"

module ref_clock_detect #(
    parameter TIMEOUT = `REF_TIMEOUT_CYCLES,
    parameter CNT_W   = `REF_CNT_W
) (
    input  wire clk_sys,     // System clock.
    input  wire rstSync_n,   // Synchronised reset, active low.
    input  wire clkEn,       // Clock enable.
    input  wire refSample,   // Reference clock after the synchroniser.
    output reg  refValid_ff  // High while reference edges keep arriving.
);

    reg             refLast_ff;
    reg [CNT_W-1:0] idleCnt_ff;
    wire            refEdge = refSample ^ refLast_ff;

    // Any edge reloads the watchdog; a silent reference lets it expire.
    // The reference must be slower than half the system clock to be seen.
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            refLast_ff  <= 1'b0;
            idleCnt_ff  <= {CNT_W{1'b0}};
            refValid_ff <= 1'b0;
        end else if (clkEn) begin
            refLast_ff <= refSample;
            if (refEdge) begin
                idleCnt_ff  <= {CNT_W{1'b0}};
                refValid_ff <= 1'b1;
            end else if (idleCnt_ff == TIMEOUT[CNT_W-1:0]) begin
                refValid_ff <= 1'b0;
            end else begin
                idleCnt_ff <= idleCnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule
